// *** core/sfcfe_consts.svh ***
// Opcodes, drive strength reset value and sequencing counts of the front end.
`ifndef SFCFE_CONSTS_SVH
`define SFCFE_CONSTS_SVH
`define OP_SET_WL     8'h06
`define OP_CLR_WL     8'h04
`define OP_VOL_WEN    8'h50
`define OP_RD_SR_LO   8'h05
`define OP_RD_SR_MID  8'h35
`define OP_RD_SR_HI   8'h15
`define OP_WR_SR_LO   8'h01
`define OP_WR_SR_MID  8'h31
`define OP_WR_SR_HI   8'h11
`define OP_READ       8'h03
`define OP_FAST_READ  8'h0b
`define OP_DUAL_OUT   8'h3b
`define OP_QUAD_OUT   8'h6b
`define OP_DUAL_IO    8'hbb
`define OP_QUAD_IO    8'heb
`define OP_QUAD_WORD  8'he7
`define OP_PROG       8'h02
`define OP_QUAD_PROG  8'h32
`define OP_FAST_PROG  8'hf2
`define OP_ERASE_4K   8'h20
`define OP_ERASE_32K  8'h52
`define OP_ERASE_64K  8'hd8
`define OP_CHIP_A     8'hc7
`define OP_CHIP_B     8'h60
`define OP_RST_ARM    8'h66
`define OP_RST_GO     8'h99
`define OP_SUSPEND    8'h75
`define OP_RESUME     8'h7a
`define DRV_RESET     2'h1
`define DUMMY_FAST    6'h08
`define DUMMY_QIO     6'h04
`define DUMMY_QWORD   6'h02
`define ADDR_LAST     2'h2
`endif

// *** core/sfcfe_pkg.sv ***
// Types shared by the serial flash command front end.
package sfcfe_pkg;
	// Sequence phases, Gray coded in the order listed.
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0, PH_OPC = 3'h1, PH_ADDR = 3'h3, PH_MODE = 3'h2,
		PH_DUMMY = 3'h6, PH_DIN = 3'h7, PH_DOUT = 3'h5, PH_SKIP = 3'h4
	} sfcfe_phase_t;
	// Commands handed to the array engine.
	typedef enum logic [3:0] {
		CK_NONE = 4'h0, CK_PROG = 4'h1, CK_ERASE_4K = 4'h2,
		CK_ERASE_32K = 4'h3, CK_ERASE_64K = 4'h4, CK_CHIP = 4'h5,
		CK_STATUS = 4'h6, CK_SUSPEND = 4'h7, CK_RESUME = 4'h8,
		CK_RESET = 4'h9
	} sfcfe_cmd_t;
endpackage

// *** core/sfcfe_core.sv ***
// Serial flash command front end with its program data FIFO.
`timescale 1ns/10ps
`include "sfcfe_consts.svh"

// ****************************************
// Program data FIFO.
// ****************************************
module sfcfe_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         flush,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	// Storage and pointers; the extra pointer bit tells full from empty.
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} sfcfe_fifo_t;
	sfcfe_fifo_t s, next_s;

	assign in_ready  = (s.wp[AW] == s.rp[AW])
		|| (s.wp[AW-1:0] != s.rp[AW-1:0]);
	assign out_valid = s.wp != s.rp;
	assign out_data  = s.mem[s.rp[AW-1:0]];

	// Flush wins so an aborted program leaves nothing behind.
	always_comb begin
		next_s = s;
		if (flush) begin
			next_s.rp = s.wp;
		end else begin
			if (in_valid && in_ready) begin
				next_s.mem[s.wp[AW-1:0]] = in_data;
				next_s.wp = s.wp + 1'b1;
			end
			if (out_valid && out_ready) begin
				next_s.rp = s.rp + 1'b1;
			end
		end
	end

	// Register the state.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule // sfcfe_fifo

// How it works
// - Lock bits at 13..11, settable individually.
// - Lock bits are one-way, cleared only on power-up.
// - Protect complement bit 14, read/write.
// - Suspend sets erase or program suspend flag.
// - Resume, reset pair clear suspend flags.
// - High performance flag mirrors mode, read-only.
// - Drive strength bits, reset value 01.
// - Bits shifted MSB first on rising clock.
// - Opcode byte, then address/data as needed.
// - Select rise stops output, deselects.
// - Write commands need clock count multiple eight.
// - Partial program byte: nothing, latch kept.
// - Status reads repeat selected byte.
// - Status writes take one data byte.
// - Plain read immediate, fast read dummy byte.
// - Programs take address then streamed data.
// - Sector and block erases take address.
// - Writes refused without write enable latch; status writes also pass with volatile enable.
// - Latch clears on power-up and completion.
// - Busy bit reads engine progress.
module sfcfe_core
	import sfcfe_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic [3:0]  io_in,
	output logic [3:0]       io_out,
	output logic [3:0]       io_oe,
	input  wire logic        busy,
	input  wire logic        erase_active,
	input  wire logic        program_active,
	input  wire logic        high_perf_operation,
	output logic [23:0]      rd_addr,
	input  wire logic [7:0]  rd_data,
	output logic             cmd_valid,
	output sfcfe_cmd_t       cmd_kind,
	output logic [23:0]      cmd_addr,
	output logic [7:0]       prog_data,
	output logic             prog_valid,
	input  wire logic        prog_ready,
	output logic             prog_overrun,
	output logic [23:0]      status_word,
	output logic [1:0]       drive_strength
);
	// ****************************************
	// State.
	// ****************************************
	typedef struct packed {
		logic         sclk_m, sclk_q, sclk_d; // Clock synchroniser.
		logic         cs_m, cs_q, cs_d;       // Select synchroniser.
		logic [3:0]   io_m, io_q;             // Data line synchroniser.
		sfcfe_phase_t ph;                     // Sequence phase.
		logic [7:0]   opc, sh;                // Opcode and input shifter.
		logic [3:0]   bitc;                   // Bits of current byte.
		logic [2:0]   clkm;                   // Clock count modulo eight.
		logic [1:0]   bcnt;                   // Address bytes taken.
		logic [5:0]   dcnt;                   // Dummy clocks left.
		logic [23:0]  addr;                   // Shifted address.
		logic [7:0]   mode_byte, wdata;       // Mode and status data.
		logic         wgot, any_data;         // Data byte seen.
		logic [7:0]   osh;                    // Output shifter.
		logic [3:0]   obits;                  // Bits sent of byte.
		logic [3:0]   io_out, io_oe;          // Pin drive.
		logic         cmd_valid;              // Command pulse.
		sfcfe_cmd_t   cmd_kind;
		logic [23:0]  cmd_addr, rd_addr;
		logic         push_v, overrun, flush; // FIFO feed.
		logic [7:0]   push_d;
		logic         wr_latch, vol_en, rst_armed, wl_pend, busy_d;
		logic [4:0]   bp;                     // Block protect field.
		logic [1:0]   srp;
		logic         qe, pcomp, esus, psus;
		logic [2:0]   lock;                   // Security lock bits.
		logic [1:0]   drv;                    // Drive strength.
		logic [23:0]  status_word;
	} sfcfe_state_t;
	sfcfe_state_t s, next_s;

	logic       fifo_in_ready; // FIFO can take the pending byte.
	logic       rise, fall, cs_rise, cs_fall, aligned, exec;
	logic [3:0] in_l, out_l, din, nbit, nob;
	logic [7:0] nsh, ob;

	// Edges are found on synchronised copies only.
	assign rise    = s.sclk_q & ~s.sclk_d & ~s.cs_q;
	assign fall    = ~s.sclk_q & s.sclk_d & ~s.cs_q;
	assign cs_rise = s.cs_q & ~s.cs_d;
	assign cs_fall = ~s.cs_q & s.cs_d;
	assign aligned = s.clkm == 3'h0;
	assign exec    = cs_rise && aligned
		&& (s.ph == PH_SKIP || s.ph == PH_DIN);

	// Lanes in use on input and output for the current opcode.
	always_comb begin
		in_l = 4'h1;
		if (s.ph == PH_ADDR || s.ph == PH_MODE) begin
			if (s.opc == `OP_DUAL_IO) begin
				in_l = 4'h2;
			end else if (s.opc == `OP_QUAD_IO || s.opc == `OP_QUAD_WORD) begin
				in_l = 4'h4;
			end
		end else if (s.ph == PH_DIN && s.opc == `OP_QUAD_PROG) begin
			in_l = 4'h4;
		end
		if (s.opc == `OP_DUAL_OUT || s.opc == `OP_DUAL_IO) begin
			out_l = 4'h2;
		end else if (s.opc == `OP_QUAD_OUT || s.opc == `OP_QUAD_IO
			|| s.opc == `OP_QUAD_WORD) begin
			out_l = 4'h4;
		end else begin
			out_l = 4'h1;
		end
		if (in_l == 4'h4) begin
			din = s.io_q;
		end else if (in_l == 4'h2) begin
			din = {2'h0, s.io_q[1:0]};
		end else begin
			din = {3'h0, s.io_q[0]};
		end
		nsh  = 8'((s.sh << in_l) | {4'h0, din});
		nbit = s.bitc + in_l;
		nob  = s.obits + out_l;
		// A new byte is fetched when the previous one is fully out.
		if (s.obits != 4'h0) begin
			ob = s.osh;
		end else if (s.opc == `OP_RD_SR_LO) begin
			ob = s.status_word[7:0];
		end else if (s.opc == `OP_RD_SR_MID) begin
			ob = s.status_word[15:8];
		end else if (s.opc == `OP_RD_SR_HI) begin
			ob = s.status_word[23:16];
		end else begin
			ob = rd_data;
		end
	end

	// ****************************************
	// Sequencer.
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.sclk_m = sclk;
		next_s.sclk_q = s.sclk_m;
		next_s.sclk_d = s.sclk_q;
		next_s.cs_m = cs_n;
		next_s.cs_q = s.cs_m;
		next_s.cs_d = s.cs_q;
		next_s.io_m = io_in;
		next_s.io_q = s.io_m;
		next_s.cmd_valid = 1'b0;
		next_s.flush = 1'b0;
		next_s.busy_d = busy;
		// The pending byte waits here while the FIFO is full.
		if (s.push_v && fifo_in_ready) begin
			next_s.push_v = 1'b0;
		end
		// The latch drops once the engine finishes its job.
		if (s.wl_pend && s.busy_d && !busy) begin
			next_s.wr_latch = 1'b0;
			next_s.wl_pend = 1'b0;
		end
		// Status image; busy and the mode flag are live inputs.
		next_s.status_word = {1'b0, s.drv, high_perf_operation,
			4'h0, s.esus, s.pcomp, s.lock, s.psus, s.qe, s.srp,
			s.bp, s.wr_latch, busy};
		if (cs_rise) begin
			// Deselect: stop driving at once, even mid-bit.
			next_s.ph = PH_IDLE;
			next_s.io_oe = 4'h0;
			next_s.rst_armed = 1'b0;
			if (s.ph == PH_DIN && !aligned) begin
				next_s.flush = 1'b1;
			end
			if (exec) begin
				unique case (s.opc)
					`OP_SET_WL: next_s.wr_latch = 1'b1;
					`OP_CLR_WL: begin
						next_s.wr_latch = 1'b0;
						next_s.vol_en = 1'b0;
					end
					`OP_VOL_WEN: next_s.vol_en = 1'b1;
					`OP_RST_ARM: next_s.rst_armed = 1'b1;
					`OP_RST_GO: begin
						if (s.rst_armed) begin
							next_s.esus = 1'b0;
							next_s.psus = 1'b0;
							next_s.wr_latch = 1'b0;
							next_s.vol_en = 1'b0;
							next_s.cmd_valid = 1'b1;
							next_s.cmd_kind = CK_RESET;
						end
					end
					`OP_SUSPEND: begin
						next_s.esus = s.esus | erase_active;
						next_s.psus = s.psus | (program_active & ~erase_active);
						next_s.cmd_valid = 1'b1;
						next_s.cmd_kind = CK_SUSPEND;
					end
					`OP_RESUME: begin
						next_s.esus = 1'b0;
						next_s.psus = 1'b0;
						next_s.cmd_valid = 1'b1;
						next_s.cmd_kind = CK_RESUME;
					end
					`OP_WR_SR_LO, `OP_WR_SR_MID, `OP_WR_SR_HI: begin
						if (s.wgot && (s.wr_latch || s.vol_en) && !busy) begin
							if (s.opc == `OP_WR_SR_LO) begin
								next_s.bp = s.wdata[6:2];
								next_s.srp[0] = s.wdata[7];
							end else if (s.opc == `OP_WR_SR_MID) begin
								next_s.srp[1] = s.wdata[0];
								next_s.qe = s.wdata[1];
								next_s.lock = s.lock | s.wdata[5:3];
								next_s.pcomp = s.wdata[6];
							end else begin
								next_s.drv = s.wdata[6:5];
							end
							next_s.vol_en = 1'b0;
							next_s.cmd_valid = s.wr_latch;
							next_s.cmd_kind = CK_STATUS;
							next_s.wl_pend = s.wr_latch;
						end
					end
					`OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K,
					`OP_CHIP_A, `OP_CHIP_B: begin
						if (s.wr_latch && !busy) begin
							next_s.cmd_valid = 1'b1;
							next_s.cmd_addr = s.addr;
							next_s.wl_pend = 1'b1;
							if (s.opc == `OP_ERASE_4K) begin
								next_s.cmd_kind = CK_ERASE_4K;
							end else if (s.opc == `OP_ERASE_32K) begin
								next_s.cmd_kind = CK_ERASE_32K;
							end else if (s.opc == `OP_ERASE_64K) begin
								next_s.cmd_kind = CK_ERASE_64K;
							end else begin
								next_s.cmd_kind = CK_CHIP;
							end
						end
					end
					`OP_PROG, `OP_QUAD_PROG, `OP_FAST_PROG: begin
						if (s.wr_latch && s.any_data && !s.overrun && !busy) begin
							next_s.cmd_valid = 1'b1;
							next_s.cmd_kind = CK_PROG;
							next_s.cmd_addr = s.addr;
							next_s.wl_pend = 1'b1;
						end else begin
							next_s.flush = 1'b1;
						end
					end
					default: ;
				endcase
			end
			// A byte still waiting outside the FIFO goes with the flush,
			// otherwise it would leak into the next program.
			if (next_s.flush) begin
				next_s.push_v = 1'b0;
			end
		end else if (cs_fall) begin
			next_s.ph = PH_OPC;
			next_s.bitc = 4'h0;
			next_s.clkm = 3'h0;
			next_s.bcnt = 2'h0;
			next_s.wgot = 1'b0;
			next_s.any_data = 1'b0;
			next_s.overrun = 1'b0;
			next_s.obits = 4'h0;
		end else if (rise) begin
			next_s.clkm = s.clkm + 3'h1;
			next_s.sh = nsh;
			next_s.bitc = (nbit == 4'h8) ? 4'h0 : nbit;
			unique case (s.ph)
				PH_OPC: begin
					if (nbit == 4'h8) begin
						next_s.opc = nsh;
						unique case (nsh)
							`OP_RD_SR_LO, `OP_RD_SR_MID, `OP_RD_SR_HI:
								next_s.ph = PH_DOUT;
							`OP_WR_SR_LO, `OP_WR_SR_MID, `OP_WR_SR_HI:
								next_s.ph = PH_DIN;
							`OP_READ, `OP_FAST_READ, `OP_DUAL_OUT, `OP_QUAD_OUT,
							`OP_DUAL_IO, `OP_QUAD_IO, `OP_QUAD_WORD, `OP_PROG,
							`OP_QUAD_PROG, `OP_FAST_PROG, `OP_ERASE_4K,
							`OP_ERASE_32K, `OP_ERASE_64K:
								next_s.ph = PH_ADDR;
							default: next_s.ph = PH_SKIP;
						endcase
					end
				end
				PH_ADDR: begin
					if (nbit == 4'h8) begin
						next_s.addr = {s.addr[15:0], nsh};
						next_s.bcnt = s.bcnt + 2'h1;
						if (s.bcnt == `ADDR_LAST) begin
							next_s.rd_addr = {s.addr[15:0], nsh};
							next_s.dcnt = `DUMMY_FAST;
							unique case (s.opc)
								`OP_READ: next_s.ph = PH_DOUT;
								`OP_FAST_READ, `OP_DUAL_OUT, `OP_QUAD_OUT:
									next_s.ph = PH_DUMMY;
								`OP_DUAL_IO, `OP_QUAD_IO, `OP_QUAD_WORD:
									next_s.ph = PH_MODE;
								`OP_PROG, `OP_QUAD_PROG, `OP_FAST_PROG:
									next_s.ph = PH_DIN;
								default: next_s.ph = PH_SKIP;
							endcase
						end
					end
				end
				PH_MODE: begin
					if (nbit == 4'h8) begin
						next_s.mode_byte = nsh;
						next_s.ph = (s.opc == `OP_DUAL_IO) ? PH_DOUT : PH_DUMMY;
						next_s.dcnt = (s.opc == `OP_QUAD_IO) ? `DUMMY_QIO
							: `DUMMY_QWORD;
					end
				end
				PH_DUMMY: begin
					next_s.dcnt = s.dcnt - 6'h1;
					if (s.dcnt == 6'h1) begin
						next_s.ph = PH_DOUT;
					end
				end
				PH_DIN: begin
					if (nbit == 4'h8) begin
						if (s.opc == `OP_WR_SR_LO || s.opc == `OP_WR_SR_MID
							|| s.opc == `OP_WR_SR_HI) begin
							next_s.wdata = nsh;
							next_s.wgot = 1'b1;
							next_s.ph = PH_SKIP;
						end else if (s.wr_latch) begin
							// Bytes flow into the FIFO; the engine acts later.
							next_s.any_data = 1'b1;
							if (s.push_v && !fifo_in_ready) begin
								next_s.overrun = 1'b1;
							end else begin
								next_s.push_v = 1'b1;
								next_s.push_d = nsh;
							end
						end
					end
				end
				default: ;
			endcase
		end else if (fall && s.ph == PH_DOUT) begin
			// Output changes on the falling edge for the host's next rise.
			if (s.obits == 4'h0 && !(s.opc == `OP_RD_SR_LO
				|| s.opc == `OP_RD_SR_MID || s.opc == `OP_RD_SR_HI)) begin
				next_s.rd_addr = s.rd_addr + 24'h1;
			end
			next_s.osh = 8'(ob << out_l);
			next_s.obits = (nob == 4'h8) ? 4'h0 : nob;
			if (out_l == 4'h4) begin
				next_s.io_out = ob[7:4];
				next_s.io_oe = 4'hf;
			end else if (out_l == 4'h2) begin
				next_s.io_out = {2'h0, ob[7:6]};
				next_s.io_oe = 4'h3;
			end else begin
				next_s.io_out = {2'h0, ob[7], 1'b0};
				next_s.io_oe = 4'h2;
			end
		end
	end

	// Register the state; reset leaves drive strength at its default.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s <= '{cs_m: 1'b1, cs_q: 1'b1, cs_d: 1'b1, ph: PH_IDLE,
				cmd_kind: CK_NONE, drv: `DRV_RESET, default: '0};
		end else begin
			s <= next_s;
		end
	end

	sfcfe_fifo #(.W(8), .D(16)) u_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.flush     (s.flush),
		.in_data   (s.push_d),
		.in_valid  (s.push_v),
		.in_ready  (fifo_in_ready),
		.out_data  (prog_data),
		.out_valid (prog_valid),
		.out_ready (prog_ready)
	);

	assign io_out         = s.io_out;
	assign io_oe          = s.io_oe;
	assign rd_addr        = s.rd_addr;
	assign cmd_valid      = s.cmd_valid;
	assign cmd_kind       = s.cmd_kind;
	assign cmd_addr       = s.cmd_addr;
	assign prog_overrun   = s.overrun;
	assign status_word    = s.status_word;
	assign drive_strength = s.drv;

	// ****************************************
	// Checks.
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_lock_one_way: assert property (&(s.lock | ~$past(s.lock)))
		else $error("security lock bit returned to zero");
	a_drv_after_rst: assert property ($fell(sys_rst) |-> s.drv == 2'h1)
		else $error("drive strength reset value wrong");
	a_suspend_sets: assert property (exec && s.opc == 8'h75 && erase_active
		|=> s.esus)
		else $error("erase suspend flag not set");
	a_resume_clear: assert property (exec && s.opc == 8'h7a
		|=> !s.esus && !s.psus)
		else $error("suspend flags not cleared by resume");
	a_deselect_oe: assert property (cs_rise |=> s.io_oe == 4'h0)
		else $error("output still driven after deselect");
	a_unaligned_rej: assert property (cs_rise && !aligned
		|=> !s.cmd_valid)
		else $error("unaligned command executed");
	a_partial_keep: assert property (cs_rise && s.ph == PH_DIN && !aligned
		|=> s.wr_latch == $past(s.wr_latch) && s.flush)
		else $error("partial program changed latch");
	a_needs_latch: assert property (s.cmd_valid && (s.cmd_kind == CK_PROG
		|| s.cmd_kind == CK_CHIP) |-> $past(s.wr_latch))
		else $error("write command without latch");
	a_only_at_rise: assert property (s.cmd_valid |-> $past(cs_rise))
		else $error("command issued mid sequence");
	a_oe_in_read: assert property (s.io_oe != 4'h0 |-> s.ph == PH_DOUT)
		else $error("pins driven outside a read");
	c_erase: cover property (s.cmd_valid && s.cmd_kind == CK_ERASE_4K);
	c_program: cover property (s.cmd_valid && s.cmd_kind == CK_PROG);
	c_quad_read: cover property (s.io_oe == 4'hf);
	c_fifo_full: cover property (s.push_v && !fifo_in_ready);
endmodule // sfcfe_core

// *** sim/sfcfe_host.sv ***
// Host controller model that drives select, link clock and data in.
`timescale 1ns/10ps
module sfcfe_host (
	input  wire logic       mclk,
	output logic            sclk,
	output logic            cs_n,
	output logic [3:0]      io_in,
	input  wire logic [3:0] io_out
);
	logic [3:0] nib; // Last nibble seen on all four lines.
	// The link clock rests low between frames.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h0;
	end
	// Waits n system edges, then steps just off the edge.
	task automatic hw(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Pulls select low; the first bit is set up a half period ahead.
	task automatic sel();
		hw(8);
		cs_n = 1'b0;
	endtask
	// Shifts n bits MSB first and samples the reply at each rise.
	task automatic shift(input logic [7:0] b, input int n,
		output logic [7:0] r);
		r = 8'h00;
		for (int i = n - 1; i >= 0; i--) begin
			io_in[0] = b[i];
			hw(8);
			sclk = 1'b1;
			r = {r[6:0], io_out[1]};
			hw(8);
			sclk = 1'b0;
		end
	endtask
	// One clock with all four lines driven; the reply nibble lands in nib.
	task automatic clk4(input logic [3:0] v);
		io_in = v;
		hw(8);
		sclk = 1'b1;
		nib = io_out;
		hw(8);
		sclk = 1'b0;
	endtask
	// Ends the frame; the released line shows the inverse of its last level.
	task automatic desel();
		hw(8);
		cs_n = 1'b1;
		io_in = ~io_in;
		hw(16);
	endtask
endmodule // sfcfe_host

// *** sim/sfcfe_core_tb.sv ***
// Self-checking bench of the serial flash command front end.
`timescale 1ns/10ps
module sfcfe_core_tb
	import sfcfe_pkg::*;
;
	logic mclk = 1'b0;
	logic sys_rst, sclk, cs_n, busy = 1'b0, prog_valid, prog_ready;
	logic erase_active, program_active, high_perf_operation;
	logic cmd_valid, prog_overrun;
	logic [3:0] io_in, io_out, io_oe;
	logic [23:0] rd_addr, cmd_addr, status_word, ga;
	logic [7:0] rd_data, prog_data, rx;
	logic [7:0] pq[$];
	logic [1:0] drive_strength;
	sfcfe_cmd_t cmd_kind, gk;
	int err_count = 0, checked = 0, nc = 0, bc = 0, cyc = 0, n0;
	logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
	sfcfe_cmd_t kinds[5] = '{CK_ERASE_4K, CK_ERASE_32K, CK_ERASE_64K,
		CK_CHIP, CK_CHIP};
	logic [7:0] q[$];
	// Wide reads: opcode, address plus dummy, clocks, last nibble, drive.
	logic [7:0] wop[4] = '{8'h3b, 8'h6b, 8'heb, 8'he7};
	logic [7:0] adr[4] = '{8'h00, 8'h00, 8'h10, 8'h00};
	int wcl[4] = '{4, 2, 14, 12};
	logic [3:0] wexp[4] = '{4'h2, 4'ha, 4'ha, 4'ha};
	logic [3:0] woe[4] = '{4'h3, 4'hf, 4'hf, 4'hf};
	always #5 mclk = ~mclk;
	// Array bytes are a simple function of the read address.
	assign rd_data = rd_addr[7:0] ^ 8'h5a;
	sfcfe_core u_sfcfe_core (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
		.cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
		.busy(busy), .erase_active(erase_active),
		.program_active(program_active),
		.high_perf_operation(high_perf_operation), .rd_addr(rd_addr),
		.rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_addr(cmd_addr), .prog_data(prog_data),
		.prog_valid(prog_valid), .prog_ready(prog_ready),
		.prog_overrun(prog_overrun), .status_word(status_word),
		.drive_strength(drive_strength));
	sfcfe_host u_sfcfe_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n),
		.io_in(io_in), .io_out(io_out));
	// Engine stand-in: records commands, runs busy for writes, drains FIFO.
	always @(posedge mclk) begin
		if (cmd_valid) begin
			gk = cmd_kind;
			ga = cmd_addr;
			nc++;
			bc = (cmd_kind inside {[CK_PROG:CK_STATUS]}) ? 20 : 0;
		end else if (bc > 0) begin
			bc--;
		end
		busy <= #1 (bc > 0);
		if (prog_valid && prog_ready) begin
			pq.push_back(prog_data);
		end
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			finish_test();
		end
	end
	// Compares a seen value against the expected one.
	task automatic chk(input string nm, input logic [23:0] got, exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Sends whole bytes plus tail loose bits, then waits out the engine.
	task automatic frame(input logic [7:0] b[$], input int tail);
		u_sfcfe_host.sel();
		foreach (b[i]) u_sfcfe_host.shift(b[i], 8, rx);
		if (tail > 0) u_sfcfe_host.shift(8'h00, tail, rx);
		u_sfcfe_host.desel();
		for (int i = 0; i < 100 && busy !== 1'b0; i++) u_sfcfe_host.hw(1);
		u_sfcfe_host.hw(4);
		chk("busy", status_word[0], 1'b0);
	endtask
	task automatic finish_test();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		erase_active = 1'b0;
		program_active = 1'b0;
		high_perf_operation = 1'b0;
		prog_ready = 1'b1;
		repeat (3) @(posedge mclk);
		#1 sys_rst = 1'b0;
		u_sfcfe_host.hw(2);
		chk("status", status_word, 24'h200000);
		chk("drive", drive_strength, 2'h1);
		// Refused writes: no latch, then a latch set on a ragged count.
		frame('{8'h31, 8'h40}, 0);
		chk("status", status_word, 24'h200000);
		frame('{8'h06}, 1);
		chk("latch", status_word[1], 1'b0);
		frame('{8'h06}, 0);
		chk("latch", status_word[1], 1'b1);
		frame('{8'h05, 8'h00, 8'h00}, 0);
		chk("sr read", rx, 8'h02);
		frame('{8'h04}, 0);
		chk("latch", status_word[1], 1'b0);
		$display("test flags done");
		// Lock bits only ever set; complement and drive are read/write.
		frame('{8'h06}, 0);
		frame('{8'h31, 8'h78}, 0);
		chk("byte mid", status_word[15:8], 8'h78);
		chk("latch", status_word[1], 1'b0);
		frame('{8'h06}, 0);
		frame('{8'h31, 8'h00}, 0);
		chk("byte mid", status_word[15:8], 8'h38);
		frame('{8'h06}, 0);
		frame('{8'h11, 8'h70}, 0);
		chk("byte high", status_word[23:16], 8'h60);
		chk("drive", drive_strength, 2'h3);
		high_perf_operation = 1'b1;
		u_sfcfe_host.hw(4);
		chk("perf", status_word[20], 1'b1);
		$display("test status done");
		// Every erase opcode, with and without an address.
		for (int i = 0; i < 5; i++) begin
			q = '{ops[i]};
			if (i < 3) q = {q, 8'h12, 8'h34, 8'h56};
			frame('{8'h06}, 0);
			frame(q, 0);
			chk("kind", gk, kinds[i]);
			if (i < 3) chk("addr", ga, 24'h123456);
		end
		// Suspend flags: cleared by resume, then by the reset pair.
		for (int j = 0; j < 2; j++) begin
			erase_active = (j == 0);
			program_active = (j == 1);
			frame('{8'h75}, 0);
			chk("suspend", status_word[j ? 10 : 15], 1'b1);
			if (j == 0) frame('{8'h7a}, 0);
			else frame('{8'h66}, 0);
			if (j == 1) frame('{8'h99}, 0);
			chk("suspend", status_word[j ? 10 : 15], 1'b0);
		end
		$display("test erase done");
		// Program, then a partial byte that must do nothing.
		pq = {};
		frame('{8'h06}, 0);
		frame('{8'h02, 8'h00, 8'h01, 8'h02, 8'ha5, 8'h3c}, 0);
		chk("kind", gk, CK_PROG);
		chk("addr", ga, 24'h000102);
		chk("data", {pq[0], pq[1]}, 16'ha53c);
		n0 = nc;
		frame('{8'h06}, 0);
		frame('{8'h02, 8'h00, 8'h01, 8'h02, 8'ha5}, 3);
		chk("count", 24'(nc - n0), 24'h0);
		chk("latch", status_word[1], 1'b1);
		// Fill the FIFO with the reader stalled, drain, then overrun it.
		// One byte more than the FIFO may wait outside it, so 18 overruns.
		for (int k = 16; k < 19; k += 2) begin
			prog_ready = 1'b0;
			pq = {};
			n0 = nc;
			q = '{8'h02, 8'h00, 8'h00, 8'h00};
			for (int i = 0; i < k; i++) q.push_back(8'(i));
			frame(q, 0);
			chk("overrun", prog_overrun, 24'(k == 18));
			chk("count", 24'(nc - n0), 24'(k == 16));
			prog_ready = 1'b1;
			u_sfcfe_host.hw(40);
			chk("drained", 24'(pq.size()), 24'(k == 16 ? 16 : 0));
			frame('{8'h06}, 0);
		end
		$display("test program done");
		// Plain and fast reads, then an unknown opcode.
		frame('{8'h03, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}, 0);
		chk("read", rx, 8'h4b);
		chk("oe", io_oe, 4'h0);
		frame('{8'h0b, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}, 0);
		chk("fast read", rx, 8'h4a);
		// Byte 4ah at 10h read on two lines, four lines, then quad address.
		for (int m = 0; m < 4; m++) begin
			u_sfcfe_host.sel();
			u_sfcfe_host.shift(wop[m], 8, rx);
			if (m < 2) begin
				foreach (adr[i]) u_sfcfe_host.shift(adr[i], 8, rx);
			end
			for (int i = 0; i < wcl[m]; i++) begin
				u_sfcfe_host.clk4((m > 1 && i == 4) ? 4'h1 : 4'h0);
			end
			chk("wide nibble", u_sfcfe_host.nib, wexp[m]);
			chk("wide oe", io_oe, woe[m]);
			u_sfcfe_host.desel();
		end
		u_sfcfe_host.sel();
		u_sfcfe_host.shift(8'h9f, 8, rx);
		u_sfcfe_host.shift(8'h00, 8, rx);
		chk("oe", io_oe, 4'h0);
		u_sfcfe_host.desel();
		$display("test read done");
		finish_test();
	end
endmodule // sfcfe_core_tb
